/* File: byte_alu_pkg.sv */
// Shared constants and types for the byte arithmetic and logic unit
package byte_alu_pkg;

  // Register byte offsets
  localparam logic [7:0] dest_offset = 8'h00;
  localparam logic [7:0] source_offset = 8'h04;
  localparam logic [7:0] command_offset = 8'h08;
  localparam logic [7:0] status_offset = 8'h0C;
  localparam logic [7:0] cycles_offset = 8'h10;

  // Field positions
  localparam int command_busy_bit = 31;
  localparam int command_op_msb = 3;
  localparam int command_op_lsb = 0;

  // Reset values
  localparam logic [15:0] dest_reset = 16'h0000;
  localparam logic [7:0] source_reset = 8'h00;
  localparam logic [1:0] cycles_reset = 2'h0;

  // Operation lengths in clocks
  localparam logic [1:0] byte_op_cycles = 2'h1;
  localparam logic [1:0] word_op_cycles = 2'h2;

  typedef enum logic [3:0] {
    op_add = 4'h0,
    op_add_with_carry = 4'h1,
    op_word_add_immediate = 4'h2,
    op_subtract = 4'h3,
    op_subtract_immediate = 4'h4,
    op_subtract_with_borrow = 4'h5,
    op_subtract_immediate_with_borrow = 4'h6,
    op_word_subtract_immediate = 4'h7,
    op_and = 4'h8,
    op_and_immediate = 4'h9,
    op_or = 4'hA,
    op_or_immediate = 4'hB,
    op_set_bits_by_mask = 4'hC
  } op_type;

  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_word_high = 2'b10
  } state_type;

  // Status flags, carry in bit 0
  typedef struct packed {
    logic [1:0] unused;
    logic h;
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
  } flags_type;

  localparam flags_type flags_reset = 8'h00;

  typedef struct packed {
    logic [7:0] res;
    logic c;
    logic h;
    logic v;
  } sum_type;

endpackage : byte_alu_pkg

/* File: byte_arith_logic_unit.sv */
// Byte arithmetic and logic unit with AHB-Lite register slave
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps

// Behaviour
// RULE1 - Add registers, optional carry, flags ZCNVH
// RULE2 - Word add immediate, flags ZCNVS, two clocks
// RULE3 - Subtract registers, optional borrow, flags ZCNVH
// RULE4 - Subtract immediate, flags ZCNVH, one clock
// RULE5 - Subtract immediate with borrow, one clock
// RULE6 - Word subtract immediate, flags ZCNVS, two clocks
// RULE7 - AND register or immediate, flags ZNV
// RULE8 - OR register or immediate, flags ZNV
// RULE9 - Set bits by mask, flags ZNV
// RULE10 - Carry from prior flags, written back
module byte_arith_logic_unit
  import byte_alu_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  // Eight-bit add or subtract with carry in
  function automatic sum_type add_sub(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin, input logic sub);
    logic [8:0] r9;
    sum_type f;
    if (sub) begin
      r9 = {1'b0, a} - {1'b0, b} - {8'h00, cin};
    end else begin
      r9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    end
    f.res = r9[7:0];
    f.c = r9[8];
    // Half carry from bit three, signed overflow
    if (sub) begin
      f.h = (~a[3] & b[3]) | (b[3] & r9[3]) | (r9[3] & ~a[3]);
      f.v = (a[7] & ~b[7] & ~r9[7]) | (~a[7] & b[7] & r9[7]);
    end else begin
      f.h = (a[3] & b[3]) | (b[3] & ~r9[3]) | (~r9[3] & a[3]);
      f.v = (a[7] & b[7] & ~r9[7]) | (~a[7] & ~b[7] & r9[7]);
    end
    return f;
  endfunction : add_sub

  logic [15:0] dest_q;
  logic [7:0] source_q;
  flags_type flags_q;
  state_type state_q;
  op_type op_q;
  logic [1:0] cycles_q;
  logic carry_low_q;
  logic zero_low_q;
  logic word_sub_q;
  logic [7:0] addr_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;

  logic accept;
  logic wr_commit;
  logic cmd_write;
  logic op_valid;
  logic start_word;
  op_type new_op;
  sum_type low_sum;
  sum_type high_sum;
  logic is_arith;
  logic is_logic;
  logic is_sub;
  logic [7:0] logic_res;
  logic [31:0] read_mux;

  assign accept = hsel & htrans[1] & hready;
  assign wr_commit = wr_pend_q & hready;
  assign cmd_write = wr_commit & (addr_q == command_offset);
  assign new_op = op_type'(hwdata[command_op_msb:command_op_lsb]);

  // Operation decode and byte datapath
  always_comb begin
    op_valid = 1'b1;
    is_arith = 1'b0;
    is_logic = 1'b0;
    is_sub = 1'b0;
    start_word = 1'b0;
    logic_res = 8'h00;
    low_sum = add_sub(dest_q[7:0], source_q, 1'b0, 1'b0);
    case (new_op)
      // RULE1 add, carry optional
      op_add: begin
        is_arith = 1'b1;
      end
      op_add_with_carry: begin
        is_arith = 1'b1;
        // RULE10 carry taken from held flags
        low_sum = add_sub(dest_q[7:0], source_q, flags_q.c, 1'b0);
      end
      // RULE2 word add low byte first
      op_word_add_immediate: begin
        start_word = 1'b1;
      end
      // RULE3 RULE4 plain subtract
      op_subtract, op_subtract_immediate: begin
        is_arith = 1'b1;
        low_sum = add_sub(dest_q[7:0], source_q, 1'b0, 1'b1);
      end
      // RULE3 RULE5 subtract with borrow
      op_subtract_with_borrow, op_subtract_immediate_with_borrow: begin
        is_arith = 1'b1;
        low_sum = add_sub(dest_q[7:0], source_q, flags_q.c, 1'b1);
      end
      // RULE6 word subtract low byte first
      op_word_subtract_immediate: begin
        start_word = 1'b1;
        is_sub = 1'b1;
        low_sum = add_sub(dest_q[7:0], source_q, 1'b0, 1'b1);
      end
      // RULE7 bitwise AND
      op_and, op_and_immediate: begin
        is_logic = 1'b1;
        logic_res = dest_q[7:0] & source_q;
      end
      // RULE8 RULE9 bitwise OR and mask set
      op_or, op_or_immediate, op_set_bits_by_mask: begin
        is_logic = 1'b1;
        logic_res = dest_q[7:0] | source_q;
      end
      default: begin
        op_valid = 1'b0;
      end
    endcase
    start_word = start_word & cmd_write;
  end

  // High byte of word operation with low carry
  always_comb begin
    high_sum = add_sub(dest_q[15:8], 8'h00, carry_low_q, word_sub_q);
  end

  // Word operation sequencing
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q <= st_idle;
      op_q <= op_add;
      carry_low_q <= 1'b0;
      zero_low_q <= 1'b0;
      word_sub_q <= 1'b0;
    end else begin
      case (state_q)
        st_idle: begin
          // RULE2 RULE6 low byte carry kept
          if (start_word) begin
            state_q <= st_word_high;
            word_sub_q <= is_sub;
            op_q <= new_op;
            carry_low_q <= low_sum.c;
            zero_low_q <= (low_sum.res == 8'h00);
          end
        end
        // RULE2 RULE6 second clock completes
        st_word_high: begin
          state_q <= st_idle;
        end
        default: begin
          state_q <= st_idle;
        end
      endcase
    end
  end

  // Destination pair and source register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dest_q <= dest_reset;
      source_q <= source_reset;
    end else begin
      if (state_q == st_word_high) begin
        // RULE2 RULE6 high byte second clock
        dest_q[15:8] <= high_sum.res;
      end else if (cmd_write & op_valid & is_logic) begin
        // RULE7 RULE8 RULE9 logic result
        dest_q[7:0] <= logic_res;
      end else if (cmd_write & op_valid) begin
        // RULE1 RULE3 RULE4 RULE5 arithmetic result
        dest_q[7:0] <= low_sum.res;
      end else if (wr_commit & (addr_q == dest_offset)) begin
        dest_q <= hwdata[15:0];
      end
      if (wr_commit & (addr_q == source_offset)) begin
        source_q <= hwdata[7:0];
      end
    end
  end

  // Status flags
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      flags_q <= flags_reset;
    end else if (state_q == st_word_high) begin
      // RULE2 RULE6 word flags
      flags_q.z <= zero_low_q & (high_sum.res == 8'h00);
      flags_q.c <= high_sum.c;
      flags_q.n <= high_sum.res[7];
      flags_q.v <= high_sum.v;
      flags_q.s <= high_sum.res[7] ^ high_sum.v;
    end else if (cmd_write & is_arith) begin
      // RULE1 RULE3 RULE4 RULE5 byte flags
      // RULE10 flags written with result
      flags_q.z <= (low_sum.res == 8'h00);
      flags_q.c <= low_sum.c;
      flags_q.n <= low_sum.res[7];
      flags_q.v <= low_sum.v;
      flags_q.h <= low_sum.h;
    end else if (cmd_write & is_logic) begin
      // RULE7 RULE8 RULE9 only Z N V
      flags_q.z <= (logic_res == 8'h00);
      flags_q.n <= logic_res[7];
      flags_q.v <= 1'b0;
    end else if (wr_commit & (addr_q == status_offset)) begin
      flags_q <= {2'b00, hwdata[5:0]};
    end
  end

  // Cycle count of last operation
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cycles_q <= cycles_reset;
    end else if (start_word) begin
      // RULE2 RULE6 two clock count
      cycles_q <= word_op_cycles;
    end else if (cmd_write & op_valid) begin
      // RULE1 RULE7 single clock count
      cycles_q <= byte_op_cycles;
    end
  end

  // Read data selection
  always_comb begin
    read_mux = 32'h0000_0000;
    case (addr_q)
      dest_offset: read_mux[15:0] = dest_q;
      source_offset: read_mux[7:0] = source_q;
      command_offset: begin
        // RULE2 RULE6 busy in second clock
        read_mux[command_busy_bit] = (state_q == st_word_high);
        read_mux[command_op_msb:command_op_lsb] = op_q;
      end
      status_offset: read_mux[7:0] = flags_q;
      cycles_offset: read_mux[1:0] = cycles_q;
      default: read_mux = 32'h0000_0000;
    endcase
  end

  // AHB-Lite address and data phase control
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      addr_q <= 8'h00;
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      // Address phase capture
      if (accept) begin
        addr_q <= (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hFF;
        wr_pend_q <= hwrite;
        rd_pend_q <= ~hwrite;
      end else if (hready) begin
        wr_pend_q <= 1'b0;
      end
      // Read answered after one wait, two if a word op starts in the same cycle
      if (rd_pend_q & (state_q == st_idle) & ~hreadyout_q) begin
        hrdata_q <= read_mux;
        rd_pend_q <= 1'b0;
      end
      // Wait states for reads and word ops
      if ((accept & ~hwrite) | start_word) begin
        hreadyout_q <= 1'b0;
      end else if (rd_pend_q & (state_q == st_idle) & ~hreadyout_q) begin
        hreadyout_q <= 1'b1;
      end else if ((state_q == st_word_high) & ~rd_pend_q) begin
        hreadyout_q <= 1'b1;
      end
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;

endmodule : byte_arith_logic_unit

/* File: alu_bus_checker.sv */
// Bus timing assertions for the byte unit
`timescale 1ns/1ps
module alu_bus_checker
  import byte_alu_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire logic taken = hsel && htrans[1] && hready;
  logic cmd_phase_q;
  // Data phase of a write to the command register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cmd_phase_q <= 1'b0;
    end else if (hready) begin
      cmd_phase_q <= taken && hwrite && (haddr == {24'h00_0000, command_offset});
    end
  end
  wire logic word_start = cmd_phase_q && hready &&
    (hwdata[3:0] == op_word_add_immediate || hwdata[3:0] == op_word_subtract_immediate);
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  chk_read_wait: assert property (taken && !hwrite |=> !hreadyout)
    else $error("read without wait state");
  chk_read_done: assert property (taken && !hwrite |-> ##[2:3] hreadyout)
    else $error("read not finished in time");
  chk_wait_short: assert property (!hreadyout |-> ##[1:2] hreadyout)
    else $error("wait state too long");
  chk_wait_cause: assert property ($fell(hreadyout) |->
    $past(taken && !hwrite) || $past(word_start))
    else $error("wait state without transfer");
  chk_idle_ready: assert property (!taken && hreadyout && !word_start |=> hreadyout)
    else $error("wait state while idle");
  chk_reset_clear: assert property ($past(sys_rst) |-> hreadyout && hrdata == 32'h0000_0000)
    else $error("bus not idle after reset");
  chk_unmapped_zero: assert property (taken && !hwrite && haddr >= 32'h0000_0014
    |-> ##[2:3] (hreadyout && hrdata == 32'h0000_0000))
    else $error("unmapped read not zero");
endmodule : alu_bus_checker
bind byte_arith_logic_unit alu_bus_checker chk (.clock(clock), .sys_rst(sys_rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

/* File: alu_bus_master.sv */
// Decoder side model issuing single bus transfers
`timescale 1ns/1ps
module alu_bus_master (
  input wire logic clock,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clock);
    while (!hready) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clock);
    while (!hready) @(posedge clock);
    rd = hrdata;
    // Released data bus shows no stale value
    hwdata <= ~wd;
  endtask : xfer
endmodule : alu_bus_master

/* File: tb_byte_arith_logic_unit.sv */
// Self-checking bench for the byte unit
`timescale 1ns/1ps
module tb_byte_arith_logic_unit;
  import byte_alu_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [63:0] c;
  int error_cnt = 0;
  int n_checks = 0;
  // Op, status in, dest, source, dest out, status out
  logic [63:0] cases [13] = '{64'h0000_0078_0800_802C, 64'h0101_00FF_0000_0023,
    64'h0220_7FFF_0180_002C, 64'h0310_0010_2000_F015, 64'h0400_0080_0100_7F28,
    64'h0501_0005_0500_FF25, 64'h0601_0005_0400_0002, 64'h0720_0000_01FF_FF35,
    64'h083F_00F0_0F00_0033, 64'h0908_12F0_8012_8004, 64'h0A00_0000_0000_0002,
    64'h0B01_0001_8000_8105, 64'h0C0A_0040_8100_C104};
  always #50 clock = ~clock;
  alu_bus_master bus (.clock(clock), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  byte_arith_logic_unit uut (.clock(clock), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic rd_chk(input logic [7:0] a, input string what, input logic [31:0] exp);
    bus.xfer(1'b0, a, 32'h0000_0000, rv);
    n_checks++;
    if (rv !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, rv);
    end
  endtask : rd_chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus.xfer(1'b1, a, d, rv);
  endtask : wr
  initial begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    rd_chk(status_offset, "status reset", 32'h0000_0000);
    rd_chk(cycles_offset, "cycles reset", 32'h0000_0000);
    foreach (cases[i]) begin
      c = cases[i];
      wr(dest_offset, {16'h0000, c[47:32]});
      wr(source_offset, {24'h00_0000, c[31:24]});
      wr(status_offset, {24'h00_0000, c[55:48]});
      wr(command_offset, {28'h000_0000, c[59:56]});
      rd_chk(dest_offset, "dest", {16'h0000, c[23:8]});
      rd_chk(status_offset, "status", {24'h00_0000, c[7:0]});
      rd_chk(cycles_offset, "cycles", {30'h0000_0000, (c[59:56] == op_word_add_immediate ||
        c[59:56] == op_word_subtract_immediate) ? word_op_cycles : byte_op_cycles});
    end
    rd_chk(command_offset, "last word op", 32'h0000_0007);
    wr(command_offset, 32'h0000_000D);
    rd_chk(dest_offset, "dest kept", 32'h0000_00C1);
    wr(8'h14, 32'hFFFF_FFFF);
    rd_chk(8'h14, "unmapped", 32'h0000_0000);
    rd_chk(source_offset, "source", 32'h0000_0081);
    // Reset in mid run clears state
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    rd_chk(dest_offset, "dest after reset", 32'h0000_0000);
    rd_chk(status_offset, "status after reset", 32'h0000_0000);
    rd_chk(cycles_offset, "cycles after reset", 32'h0000_0000);
    conclude();
  end
endmodule : tb_byte_arith_logic_unit
